// file: hw/crs_pkg.sv
// Constants and types shared by the clock, reset and strap control block.
// Assumes a single 100 MHz management clock drives every file that imports it.
package crs_pkg;

  localparam int CLK_PERIOD_NS = 10;

  // Internal oscillator warm-up period after any reset
  localparam int WARM_CYC = 1024;
  localparam int WARM_W   = $clog2(WARM_CYC) + 1;
  localparam logic [WARM_W-1:0] WARM_LAST = WARM_W'(WARM_CYC - 1);

  // Reset pin filter, least low time rounded up to whole cycles
  localparam int RST_FILT_NS  = 1000;
  localparam int RST_FILT_CYC = (RST_FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RST_FILT_W   = $clog2(RST_FILT_CYC) + 1;
  localparam logic [RST_FILT_W-1:0] RST_FILT_LAST = RST_FILT_W'(RST_FILT_CYC - 1);

  // Reset timer after all reset causes are gone
  localparam int RST_TMR_CYC = 4096;
  localparam int RST_TMR_W   = $clog2(RST_TMR_CYC);
  localparam logic [RST_TMR_W-1:0] RST_TMR_LAST = RST_TMR_W'(RST_TMR_CYC - 1);

  // Processor fetch address after reset
  localparam int ADDR_W = 24;
  localparam logic [ADDR_W-1:0] START_ADDR = 24'h000000;

  // Synchroniser reset values: {sel, six, spi_serial_clock_pin, mp0, family, osc, rst_pin, supply}
  localparam int SYNC_W = 8;
  localparam logic [SYNC_W-1:0] SYNC_RST = 8'h06;
  localparam int SY_SUPPLY = 0;
  localparam int SY_RSTPIN = 1;
  localparam int SY_OSC    = 2;
  localparam int SY_FAMILY = 3;
  localparam int SY_MP0    = 4;
  localparam int SY_SPI_SERIAL_CLOCK_PIN   = 5;
  localparam int SY_SIX    = 6;
  localparam int SY_SEL    = 7;

  // Reset sequencer, Gray along hold -> timer -> run
  typedef enum logic [1:0] {
    ST_HOLD  = 2'h0,
    ST_TIMER = 2'h1,
    ST_RUN   = 2'h3
  } crs_state_t;

  typedef enum logic [1:0] {
    MODE_SPI  = 2'h0,
    MODE_UART = 2'h1,
    MODE_I2C  = 2'h2
  } crs_mode_t;

  function automatic crs_mode_t crs_decode_mode(input logic family, input logic kind);
    if (!family) begin
      return MODE_SPI;
    end else if (kind) begin
      return MODE_I2C;
    end else begin
      return MODE_UART;
    end
  endfunction : crs_decode_mode

endpackage : crs_pkg

// file: hw/crs_osc_if.sv
// Signals between the reset sequencer and the oscillator selector.
// Assumes both ends share the management clock.
`timescale 1ns/1ps
interface crs_osc_if;
  logic restart;
  logic ext_clk_s;
  logic sel_ext;
  logic alive;
  logic osc_fail;

  modport seq (output restart, output ext_clk_s, input sel_ext, input alive, input osc_fail);
  modport osc (input restart, input ext_clk_s, output sel_ext, output alive, output osc_fail);
endinterface : crs_osc_if

// file: hw/crs_osc_sel.sv
// Clock source selector: internal start-up period, external handover, fallback.
// Assumes ext_clk_s is already synchronised and restart is a one-cycle pulse.
`timescale 1ns/1ps
module crs_osc_sel
  import crs_pkg::*;
#(
  parameter int OSC_MISS_CYC = 16
) (
  input  wire logic clk_i,
  input  wire logic resetn_i,
  input  wire logic ce_i,
  crs_osc_if.osc    osc
);

  localparam int MISS_W = $clog2(OSC_MISS_CYC) + 1;
  localparam logic [MISS_W-1:0] MISS_LAST = MISS_W'(OSC_MISS_CYC - 1);

  if (OSC_MISS_CYC < 2) begin : g_chk
    $error("OSC_MISS_CYC must be at least 2");
  end

  logic [WARM_W-1:0] warm_cnt_r;
  logic              warm_done_r;
  logic [MISS_W-1:0] miss_cnt_r;
  logic              ext_d_r;
  logic              alive_r;
  logic              sel_ext_r;
  logic              fail_r;
  logic              edge_seen;
  logic              fail_set;

  ////////////////////////////////////////////////////////////////////////////
  // Edge watch on the external clock; a stuck pin looks like a dead oscillator
  assign edge_seen = ext_d_r ^ osc.ext_clk_s;
  assign fail_set  = sel_ext_r & ~alive_r;

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      warm_cnt_r  <= '0;
      warm_done_r <= 1'b0;
    end else if (ce_i) begin
      if (osc.restart) begin
        warm_cnt_r  <= '0;
        warm_done_r <= 1'b0;
      end else if (!warm_done_r) begin
        warm_cnt_r  <= warm_cnt_r + 1'b1;
        warm_done_r <= (warm_cnt_r == WARM_LAST);
      end
    end
  end

  // Reset level matches the synchroniser so no false edge follows reset
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      ext_d_r    <= SYNC_RST[SY_OSC];
      miss_cnt_r <= '0;
      alive_r    <= 1'b0;
    end else if (ce_i) begin
      ext_d_r <= osc.ext_clk_s;
      if (edge_seen) begin
        miss_cnt_r <= '0;
        alive_r    <= 1'b1;
      end else if (miss_cnt_r == MISS_LAST) begin
        alive_r    <= 1'b0;
      end else begin
        miss_cnt_r <= miss_cnt_r + 1'b1;
      end
    end
  end

  // Fallback needs no software: dead source drops the selection at once
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      sel_ext_r <= 1'b0;
      fail_r    <= 1'b0;
    end else if (ce_i) begin
      sel_ext_r <= ~osc.restart & warm_done_r & alive_r;
      if (fail_set) begin
        fail_r <= 1'b1;
      end else if (osc.restart) begin
        fail_r <= 1'b0;
      end
    end
  end

  assign osc.sel_ext  = sel_ext_r;
  assign osc.alive    = alive_r;
  assign osc.osc_fail = fail_r;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  logic [WARM_W:0] since_rst_r;
  always_ff @(posedge clk_i) begin
    if (!resetn_i || osc.restart) begin
      since_rst_r <= '0;
    end else if (ce_i && since_rst_r != {1'b1, {WARM_W{1'b0}}}) begin
      since_rst_r <= since_rst_r + 1'b1;
    end
  end

  property p_warm;
    @(posedge clk_i) disable iff (!resetn_i || !ce_i)
      sel_ext_r |-> since_rst_r >= (WARM_W + 1)'(WARM_CYC);
  endproperty
  a_warm: assert property (p_warm) else $error("external clock chosen too early");

  property p_handover;
    @(posedge clk_i) disable iff (!resetn_i || !ce_i)
      (warm_done_r && alive_r && !osc.restart) |=> sel_ext_r;
  endproperty
  a_handover: assert property (p_handover) else $error("no handover to external clock");

  property p_fallback;
    @(posedge clk_i) disable iff (!resetn_i || !ce_i)
      (sel_ext_r && !alive_r) |=> !sel_ext_r ##1 !sel_ext_r;
  endproperty
  a_fallback: assert property (p_fallback) else $error("dead oscillator kept");

  property p_fail_flag;
    @(posedge clk_i) disable iff (!resetn_i || !ce_i)
      (sel_ext_r && !alive_r) |=> fail_r;
  endproperty
  a_fail_flag: assert property (p_fail_flag) else $error("oscillator failure not flagged");

endmodule : crs_osc_sel

// file: hw/crs_top.sv
// Clock, reset and strap control: reset sources, reset timer, strap capture.
// Assumes clk_i is the always-running management clock; pins arrive asynchronous.
//
// Overview of operation
// - After any reset the internal oscillator runs for the first 1024 cycles.
// - After that period the selector takes the external clock if it is running.
// - A failing external oscillator drops back to the internal one without software.
// - External oscillator failure is reported as a status flag.
// - While the reset pin is low, all logic except clock management halts.
// - The reset pin must stay low at least 1 us before a reset starts.
// - Reset lasts until the pin is high and a 4096-cycle timer expires.
// - At release the processor starts fetching at address zero.
// - Supply detector starts the sequence at power-up and forces reset on a drop.
// - A watchdog timeout forces full reset; software refreshes it to avoid that.
// - Interface and address straps are sampled at reset to pick interface and address.
// - Family strap low selects SPI; high defers to the second strap.
// - Second strap on multipurpose pin zero: high I2C, low UART.
// - Once running, exactly one serial interface is enabled; the others stay off. In reset all three are off.
// - SPI clock pin is address bit zero unless SPI; pin six is address bit one.
// - Select pin: SPI slave select, RS-485 direction for UART, I2C clock.
`timescale 1ns/1ps
module crs_top
  import crs_pkg::*;
#(
  parameter int WDT_TIMEOUT_CYC = 1000000,
  parameter int OSC_MISS_CYC    = 16
) (
  input  wire logic              clk_i,
  input  wire logic              resetn_i,
  input  wire logic              ce_i,
  input  wire logic              supply_ok_i,
  input  wire logic              ext_reset_n_i,
  input  wire logic              osc_out_pin_i,
  input  wire logic              wdt_refresh_i,
  input  wire logic              iface_family_strap_i,
  input  wire logic              multipurpose_pin_zero_i,
  input  wire logic              spi_serial_clock_pin_i,
  input  wire logic              multipurpose_pin_six_i,
  input  wire logic              sel_pin_i,
  input  wire logic              rs485_dir_i,
  output logic                   sys_reset_n_o,
  output logic [ADDR_W-1:0]      core_start_addr_o,
  output logic                   clk_sel_ext_o,
  output logic                   osc_fail_flag_o,
  output logic                   wdt_reset_flag_o,
  output logic                   spi_en_o,
  output logic                   uart_en_o,
  output logic                   i2c_en_o,
  output logic [1:0]             addr_strap_o,
  output logic                   spi_serial_clock_o,
  output logic                   spi_slave_select_n_o,
  output logic                   i2c_scl_o,
  output logic                   sel_pin_o,
  output logic                   sel_pin_oe_n_o
);

  localparam int WDT_W = $clog2(WDT_TIMEOUT_CYC) + 1;
  localparam logic [WDT_W-1:0] WDT_LAST = WDT_W'(WDT_TIMEOUT_CYC - 1);

  if (WDT_TIMEOUT_CYC < 2) begin : g_chk
    $error("WDT_TIMEOUT_CYC must be at least 2");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers
  logic [SYNC_W-1:0] meta_r;
  logic [SYNC_W-1:0] sync_r;
  logic [SYNC_W-1:0] pins;

  assign pins = {sel_pin_i, multipurpose_pin_six_i, spi_serial_clock_pin_i,
                 multipurpose_pin_zero_i, iface_family_strap_i, osc_out_pin_i,
                 ext_reset_n_i, supply_ok_i};

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      meta_r <= SYNC_RST;
      sync_r <= SYNC_RST;
    end else if (ce_i) begin
      meta_r <= pins;
      sync_r <= meta_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reset pin filter; short glitches on a noisy board never start a reset
  logic [RST_FILT_W-1:0] filt_cnt_r;
  logic                  pin_rst_r;
  logic                  pin_low;

  assign pin_low = ~sync_r[SY_RSTPIN];

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      filt_cnt_r <= '0;
      pin_rst_r  <= 1'b0;
    end else if (ce_i) begin
      if (!pin_low) begin
        filt_cnt_r <= '0;
      end else if (filt_cnt_r != RST_FILT_LAST) begin
        filt_cnt_r <= filt_cnt_r + 1'b1;
      end
      pin_rst_r <= pin_low & (pin_rst_r | (filt_cnt_r == RST_FILT_LAST));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reset sequencer
  crs_state_t           st_r;
  crs_state_t           st_nxt;
  logic [RST_TMR_W-1:0] tmr_r;
  logic                 wdt_bite_r;
  logic                 cause_any;
  logic                 tmr_done;
  logic                 release_now;
  logic                 running;

  assign cause_any   = ~sync_r[SY_SUPPLY] | pin_rst_r | wdt_bite_r;
  assign tmr_done    = (tmr_r == RST_TMR_LAST);
  assign running     = (st_r == ST_RUN);
  assign release_now = (st_r == ST_TIMER) & tmr_done & ~cause_any;

  always_comb begin
    st_nxt = st_r;
    case (st_r)
      ST_HOLD: begin
        if (!cause_any) begin
          st_nxt = ST_TIMER;
        end
      end
      ST_TIMER: begin
        if (cause_any) begin
          st_nxt = ST_HOLD;
        end else if (tmr_done) begin
          st_nxt = ST_RUN;
        end
      end
      ST_RUN: begin
        if (cause_any) begin
          st_nxt = ST_HOLD;
        end
      end
      default: begin
        st_nxt = ST_HOLD;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      st_r  <= ST_HOLD;
      tmr_r <= '0;
    end else if (ce_i) begin
      st_r  <= st_nxt;
      tmr_r <= (st_r == ST_TIMER && st_nxt == ST_TIMER) ? tmr_r + 1'b1 : '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog, free running while the processor runs
  logic [WDT_W-1:0] wdt_cnt_r;

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      wdt_cnt_r  <= '0;
      wdt_bite_r <= 1'b0;
    end else if (ce_i) begin
      wdt_bite_r <= running & ~wdt_refresh_i & (wdt_cnt_r == WDT_LAST);
      if (!running || wdt_refresh_i || wdt_cnt_r == WDT_LAST) begin
        wdt_cnt_r <= '0;
      end else begin
        wdt_cnt_r <= wdt_cnt_r + 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Oscillator selection
  crs_osc_if osc_bus ();
  logic      restart_r;

  assign osc_bus.restart   = restart_r;
  assign osc_bus.ext_clk_s = sync_r[SY_OSC];

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      restart_r <= 1'b0;
    end else if (ce_i) begin
      restart_r <= (st_nxt == ST_HOLD) & (st_r != ST_HOLD);
    end
  end

  crs_osc_sel #(
    .OSC_MISS_CYC (OSC_MISS_CYC)
  ) u_osc_sel (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .ce_i     (ce_i),
    .osc      (osc_bus.osc)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Strap capture; values frozen until the next reset of any kind
  logic       family_lat_r;
  logic       kind_lat_r;
  logic [1:0] addr_lat_r;
  crs_mode_t  mode;

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      family_lat_r <= 1'b0;
      kind_lat_r   <= 1'b0;
      addr_lat_r   <= 2'h0;
    end else if (ce_i && release_now) begin
      family_lat_r <= sync_r[SY_FAMILY];
      kind_lat_r   <= sync_r[SY_MP0];
      addr_lat_r   <= {sync_r[SY_SIX], sync_r[SY_SPI_SERIAL_CLOCK_PIN]};
    end
  end

  assign mode = crs_decode_mode(family_lat_r, kind_lat_r);

  ////////////////////////////////////////////////////////////////////////////
  // Registered outputs and pin routing
  logic spi_nxt;
  logic uart_nxt;
  logic i2c_nxt;
  logic run_nxt;

  assign run_nxt  = (st_nxt == ST_RUN);
  assign spi_nxt  = running & (mode == MODE_SPI);
  assign uart_nxt = running & (mode == MODE_UART);
  assign i2c_nxt  = running & (mode == MODE_I2C);

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      sys_reset_n_o     <= 1'b0;
      core_start_addr_o <= START_ADDR;
      clk_sel_ext_o     <= 1'b0;
      osc_fail_flag_o   <= 1'b0;
      wdt_reset_flag_o  <= 1'b0;
    end else if (ce_i) begin
      sys_reset_n_o     <= run_nxt;
      core_start_addr_o <= START_ADDR;
      clk_sel_ext_o     <= osc_bus.sel_ext;
      osc_fail_flag_o   <= osc_bus.osc_fail;
      if (wdt_bite_r) begin
        wdt_reset_flag_o <= 1'b1;
      end else if (!sync_r[SY_SUPPLY]) begin
        wdt_reset_flag_o <= 1'b0;
      end
    end
  end

  // Pin routing lags the synchronised pins by one cycle so every output stays a flop
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      spi_en_o             <= 1'b0;
      uart_en_o            <= 1'b0;
      i2c_en_o             <= 1'b0;
      addr_strap_o         <= 2'h0;
      spi_serial_clock_o   <= 1'b0;
      spi_slave_select_n_o <= 1'b1;
      i2c_scl_o            <= 1'b1;
      sel_pin_o            <= 1'b0;
      sel_pin_oe_n_o       <= 1'b1;
    end else if (ce_i) begin
      spi_en_o             <= spi_nxt;
      uart_en_o            <= uart_nxt;
      i2c_en_o             <= i2c_nxt;
      addr_strap_o         <= {addr_lat_r[1], addr_lat_r[0] & (mode != MODE_SPI)};
      spi_serial_clock_o   <= spi_nxt & sync_r[SY_SPI_SERIAL_CLOCK_PIN];
      spi_slave_select_n_o <= spi_nxt ? sync_r[SY_SEL] : 1'b1;
      i2c_scl_o            <= i2c_nxt ? sync_r[SY_SEL] : 1'b1;
      sel_pin_o            <= uart_nxt & rs485_dir_i;
      sel_pin_oe_n_o       <= ~uart_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_timer_end;
    (st_r == ST_TIMER) && tmr_done && !cause_any;
  endsequence

  property p_release;
    @(posedge clk_i) disable iff (!resetn_i || !ce_i)
      s_timer_end |=> sys_reset_n_o && (core_start_addr_o == START_ADDR);
  endproperty
  a_release: assert property (p_release) else $error("reset not released");

  property p_release_cause;
    @(posedge clk_i) disable iff (!resetn_i || !ce_i)
      $rose(sys_reset_n_o) |-> $past(st_r) == ST_TIMER && $past(tmr_r) == RST_TMR_LAST;
  endproperty
  a_release_cause: assert property (p_release_cause) else $error("early release");

  property p_filter;
    @(posedge clk_i) disable iff (!resetn_i || !ce_i)
      $rose(pin_rst_r) |-> $past(filt_cnt_r) == RST_FILT_LAST;
  endproperty
  a_filter: assert property (p_filter) else $error("reset pin filter too short");

  property p_pin_halt;
    @(posedge clk_i) disable iff (!resetn_i || !ce_i)
      pin_rst_r |=> !sys_reset_n_o;
  endproperty
  a_pin_halt: assert property (p_pin_halt) else $error("runs during pin reset");

  property p_supply;
    @(posedge clk_i) disable iff (!resetn_i || !ce_i)
      !sync_r[SY_SUPPLY] |=> !sys_reset_n_o ##1 st_r != ST_RUN;
  endproperty
  a_supply: assert property (p_supply) else $error("supply drop without reset");

  property p_wdt;
    @(posedge clk_i) disable iff (!resetn_i || !ce_i)
      (running && !wdt_refresh_i && wdt_cnt_r == WDT_LAST) |=> ##1 !sys_reset_n_o;
  endproperty
  a_wdt: assert property (p_wdt) else $error("watchdog timeout ignored");

  property p_wdt_flag;
    @(posedge clk_i) disable iff (!resetn_i || !ce_i)
      wdt_bite_r |=> wdt_reset_flag_o;
  endproperty
  a_wdt_flag: assert property (p_wdt_flag) else $error("watchdog reset not flagged");

  property p_onehot;
    @(posedge clk_i) disable iff (!resetn_i || !ce_i)
      sys_reset_n_o |=> (spi_en_o + uart_en_o + i2c_en_o) == 2'h1;
  endproperty
  a_onehot: assert property (p_onehot) else $error("serial enables not one-hot");

  property p_mode;
    @(posedge clk_i) disable iff (!resetn_i || !ce_i)
      release_now |=> ##1 spi_en_o == !$past(sync_r[SY_FAMILY], 2)
                      && i2c_en_o == ($past(sync_r[SY_FAMILY], 2) && $past(sync_r[SY_MP0], 2));
  endproperty
  a_mode: assert property (p_mode) else $error("strap decode wrong");

  property p_hold;
    @(posedge clk_i) disable iff (!resetn_i || !ce_i)
      (sys_reset_n_o && $past(sys_reset_n_o)) |-> $stable(addr_lat_r) && $stable(family_lat_r);
  endproperty
  a_hold: assert property (p_hold) else $error("straps changed while running");

endmodule : crs_top

// file: testbench/crs_partner.sv
// Board model: external 20 MHz oscillator, reset driver with pull-up, strap wiring.
// Assumes the bench commands it at clk_i rising edges.
`timescale 1ns/1ps
module crs_partner (
  input  wire logic       osc_en_i,
  input  wire logic       rst_low_i,
  input  wire logic [4:0] strap_i,
  output logic            osc_out_pin_o,
  output logic            ext_reset_n_o,
  output logic [4:0]      pins_o
);
  ////////////////////////////////////////////////////////////////////////////////
  // A dead oscillator freezes at its last level, so only missing edges show it
  // Offset keeps pin edges away from the sampling clock edges
  initial begin
    osc_out_pin_o = 1'h0;
    #3;
    forever begin
      #25;
      if (osc_en_i) begin
        osc_out_pin_o = ~osc_out_pin_o;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Released pin floats up through the board pull-up
  assign ext_reset_n_o = rst_low_i ? 1'h0 : 1'h1;
  // Straps: {sel, six, spi_serial_clock_pin, mp0, family}, levels set by the bench
  assign pins_o = strap_i;
endmodule : crs_partner

// file: testbench/tb_top.sv
// Self-checking bench for the clock, reset and strap control top.
// Assumes the board model above and a short watchdog timeout for run time.
`timescale 1ns/1ps
module tb_top;
  import crs_pkg::*;
  logic              clk_i, resetn_i, supply_ok_i, wdt_refresh_i, rs485_dir_i;
  logic              osc_en, rst_low, ce_i;
  logic [4:0]        strap;
  wire logic         osc_pin, rst_pin;
  wire logic [4:0]   pins;
  logic              sys_reset_n_o, clk_sel_ext_o, osc_fail_flag_o, wdt_reset_flag_o;
  logic              spi_en_o, uart_en_o, i2c_en_o, spi_serial_clock_o;
  logic              spi_slave_select_n_o, i2c_scl_o, sel_pin_o, sel_pin_oe_n_o;
  logic [ADDR_W-1:0] core_start_addr_o;
  logic [1:0]        addr_strap_o;
  int                failures, samples_checked, cyc;

  crs_partner i_crs_partner (.osc_en_i(osc_en), .rst_low_i(rst_low), .strap_i(strap),
    .osc_out_pin_o(osc_pin), .ext_reset_n_o(rst_pin), .pins_o(pins));

  // Short watchdog keeps the bite scenario brief
  crs_top #(.WDT_TIMEOUT_CYC(50), .OSC_MISS_CYC(16)) i_crs_top (
    .clk_i(clk_i), .resetn_i(resetn_i), .ce_i(ce_i), .supply_ok_i(supply_ok_i),
    .ext_reset_n_i(rst_pin), .osc_out_pin_i(osc_pin), .wdt_refresh_i(wdt_refresh_i),
    .iface_family_strap_i(pins[0]), .multipurpose_pin_zero_i(pins[1]),
    .spi_serial_clock_pin_i(pins[2]), .multipurpose_pin_six_i(pins[3]),
    .sel_pin_i(pins[4]), .rs485_dir_i(rs485_dir_i), .sys_reset_n_o(sys_reset_n_o),
    .core_start_addr_o(core_start_addr_o), .clk_sel_ext_o(clk_sel_ext_o),
    .osc_fail_flag_o(osc_fail_flag_o), .wdt_reset_flag_o(wdt_reset_flag_o),
    .spi_en_o(spi_en_o), .uart_en_o(uart_en_o), .i2c_en_o(i2c_en_o),
    .addr_strap_o(addr_strap_o), .spi_serial_clock_o(spi_serial_clock_o),
    .spi_slave_select_n_o(spi_slave_select_n_o), .i2c_scl_o(i2c_scl_o),
    .sel_pin_o(sel_pin_o), .sel_pin_oe_n_o(sel_pin_oe_n_o));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string nm, input logic [23:0] seen, input logic [23:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask : check

  // Sample 1 ns after the edge so its updates have landed
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : tick

  task automatic wait_run(input logic lvl, input int lim, output int n);
    n = 0;
    while (sys_reset_n_o !== lvl && n < lim) begin
      tick(1);
      n++;
    end
  endtask : wait_run

  task automatic final_report;
    $display("Checks %0d, mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : final_report

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_powerup;
    int n;
    tick(1000);
    check("int clock early", clk_sel_ext_o, 1'h0);
    check("held early", sys_reset_n_o, 1'h0);
    tick(60);
    check("ext clock", clk_sel_ext_o, 1'h1);
    wait_run(1'h1, 3200, n);
    check("power-up delay", n + 1060 >= 4090 && n + 1060 <= 4110, 1'h1);
    check("fetch addr", core_start_addr_o, 24'h000000);
    $display("Done: power-up");
  endtask : t_powerup

  task automatic t_osc;
    check("fail flag idle", osc_fail_flag_o, 1'h0);
    @(posedge clk_i);
    osc_en <= 1'h0;
    tick(40);
    check("fallback", clk_sel_ext_o, 1'h0);
    check("fail flag", osc_fail_flag_o, 1'h1);
    check("no reset", sys_reset_n_o, 1'h1);
    @(posedge clk_i);
    osc_en <= 1'h1;
    $display("Done: oscillator failure");
  endtask : t_osc

  // A 50-cycle low is half the filter time and must leave the core running
  task automatic t_short;
    @(posedge clk_i);
    rst_low <= 1'h1;
    tick(50);
    @(posedge clk_i);
    rst_low <= 1'h0;
    repeat (200) begin
      tick(1);
      check("glitch ignored", sys_reset_n_o, 1'h1);
    end
    $display("Done: short reset pulse");
  endtask : t_short

  // Frozen cycles must not see a supply drop, so the core keeps running
  task automatic t_ce;
    @(posedge clk_i);
    ce_i        <= 1'h0;
    supply_ok_i <= 1'h0;
    tick(20);
    check("ce freeze", sys_reset_n_o, 1'h1);
    @(posedge clk_i);
    supply_ok_i <= 1'h1;
    tick(2);
    @(posedge clk_i);
    ce_i <= 1'h1;
    tick(10);
    check("ce resume", sys_reset_n_o, 1'h1);
    $display("Done: clock enable");
  endtask : t_ce

  task automatic t_mode(input string nm, input logic fam, mp0, six, spi_serial_clock_pin);
    int n;
    @(posedge clk_i);
    strap   <= {1'h1, six, spi_serial_clock_pin, mp0, fam};
    rst_low <= 1'h1;
    tick(120);
    check("held in reset", sys_reset_n_o, 1'h0);
    @(posedge clk_i);
    rst_low <= 1'h0;
    wait_run(1'h1, 4300, n);
    check("release delay", n >= 4090 && n <= 4110, 1'h1);
    check("fail flag cleared", osc_fail_flag_o, 1'h0);
    // Pins move after release; latched straps must not follow
    @(posedge clk_i);
    strap       <= {1'h0, six, ~spi_serial_clock_pin, mp0, ~fam};
    rs485_dir_i <= 1'h1;
    tick(5);
    check("spi_en", spi_en_o, !fam);
    check("uart_en", uart_en_o, fam & !mp0);
    check("i2c_en", i2c_en_o, fam & mp0);
    check("addr", addr_strap_o, {six, spi_serial_clock_pin & fam});
    check("spi_serial_clock_pin out", spi_serial_clock_o, !fam & ~spi_serial_clock_pin);
    check("ss_n", spi_slave_select_n_o, fam);
    check("scl", i2c_scl_o, !(fam & mp0));
    check("dir", sel_pin_o, fam & !mp0);
    check("dir oe_n", sel_pin_oe_n_o, !(fam & !mp0));
    @(posedge clk_i);
    rs485_dir_i <= 1'h0;
    $display("Done: mode %s", nm);
  endtask : t_mode

  task automatic t_wdt;
    int n;
    @(posedge clk_i);
    wdt_refresh_i <= 1'h0;
    wait_run(1'h0, 80, n);
    check("bite delay", n >= 48 && n <= 56, 1'h1);
    check("wdt flag", wdt_reset_flag_o, 1'h1);
    @(posedge clk_i);
    wdt_refresh_i <= 1'h1;
    wait_run(1'h1, 4300, n);
    check("wdt recovery", n >= 4090 && n <= 4110, 1'h1);
    $display("Done: watchdog");
  endtask : t_wdt

  task automatic t_supply;
    int n;
    @(posedge clk_i);
    supply_ok_i <= 1'h0;
    tick(6);
    check("supply drop", sys_reset_n_o, 1'h0);
    check("wdt flag lost", wdt_reset_flag_o, 1'h0);
    tick(20);
    @(posedge clk_i);
    supply_ok_i <= 1'h1;
    wait_run(1'h1, 4300, n);
    check("supply return", n >= 4090 && n <= 4110, 1'h1);
    $display("Done: supply");
  endtask : t_supply

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_i = 1'h0;
    forever #5 clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 40000) begin
      failures++;
      final_report();
    end
  end

  // Refresh is held as a level so only the watchdog scenario lets it bite
  initial begin
    resetn_i = 1'h0;
    supply_ok_i = 1'h1;
    wdt_refresh_i = 1'h1;
    rs485_dir_i = 1'h0;
    osc_en = 1'h1;
    rst_low = 1'h0;
    ce_i = 1'h1;
    strap = 5'h00;
    repeat (2) @(posedge clk_i);
    resetn_i <= 1'h1;
    t_powerup();
    t_osc();
    t_short();
    t_ce();
    t_mode("spi", 1'h0, 1'h1, 1'h1, 1'h1);
    t_mode("uart", 1'h1, 1'h0, 1'h1, 1'h0);
    t_mode("i2c", 1'h1, 1'h1, 1'h0, 1'h1);
    t_wdt();
    t_supply();
    final_report();
  end
endmodule : tb_top
